// ---- inc/startup_seq_regs.vh ----
// Constants for the configuration start-up sequencer
`ifndef STARTUP_SEQ_REGS_VH
`define STARTUP_SEQ_REGS_VH

// Wishbone register byte offsets
`define ADDR_W 4
`define OFS_CTRL 4'h0
`define OFS_LENGTH 4'h4
`define OFS_STATUS 4'h8
`define OFS_COUNT 4'hC

// Start-up shift register
`define STAGE_W 5
`define STAGE_LAST 4
`define STAGE_WAIT 3
`define TAP_W 3

// Configuration clock counter
`define CNT_W 24
`define LENGTH_RST 24'hFFFFFF

// Control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_WAIT_BIT 0
`define CTRL_USER_BIT 1
`define CTRL_DTAP_LO 4
`define CTRL_DTAP_HI 6
`define CTRL_ITAP_LO 8
`define CTRL_ITAP_HI 10
`define CTRL_GTAP_LO 12
`define CTRL_GTAP_HI 14
`define CTRL_RESTART 31

// Clock modes
`define MODE_OSC_FREE 2'h0
`define MODE_OSC_WAIT 2'h1
`define MODE_USER_FREE 2'h2
`define MODE_USER_WAIT 2'h3

// Control reset values
`define MODE_RST `MODE_OSC_FREE
`define DTAP_RST 3'h1
`define ITAP_RST 3'h2
`define GTAP_RST 3'h3

// Status register fields
`define ST_STAGE_LO 0
`define ST_STAGE_HI 4
`define ST_MATCH 9
`define ST_MEMFULL 10
`define ST_DONELINE 11
`define ST_IOACT 12
`define ST_GSRHOLD 13
`define ST_DONEREL 14

`endif

// ---- rtl/pin_sync_edge.v ----
// Two-flop pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
module pin_sync_edge (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Asynchronous pin
  input wire pinIn,
  // Synchronised level and one-cycle rising-edge pulse
  output wire level,
  output wire rise
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge detect looks only at the second and third flops
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule // pin_sync_edge

// ---- rtl/config_length_counter.v ----
// Configuration clock counter compared against the loaded length count
`include "startup_seq_regs.vh"
`timescale 1ns/1ps
module config_length_counter (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire clear,
  input wire countEn,
  input wire [`CNT_W-1:0] lengthCount,
  // Results
  output wire [`CNT_W-1:0] count,
  output wire match
);
  reg [`CNT_W-1:0] count_q;
  wire [`CNT_W-1:0] count_d;

  // Wraps like the real counter, so a miscount needs a full turn to match
  assign count_d = count_q + {{(`CNT_W-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (srst || clear) begin
      count_q <= {`CNT_W{1'b0}};
    end else if (countEn) begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
  assign match = (count_q == lengthCount);
endmodule // config_length_counter

// ---- rtl/config_startup_sequencer.v ----
// Start-up sequencer run after configuration, with Wishbone registers
//
// Contract
// - Start only when memory full, count matches
// - First clock edge after start sets stage zero
// - Taps drive done, io blocks, set/reset
// - Default: done, io next clock, reset after
// - Default clock is configuration oscillator, asynchronous
// - Later stages clocked by oscillator or user
// - Wait modes gate stage three on line
// - Held-low done line stalls progress until high
// - Free-run modes ignore the done line
// - Stage one bridges oscillator and user clock
// - Length count loaded and held for compare
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`include "startup_seq_regs.vh"
`timescale 1ns/1ps
module config_startup_sequencer (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Configuration side
  input wire configOscClock,
  input wire userStartupClock,
  input wire clearFinished,
  input wire memFull,
  // Wired-AND done line
  input wire doneLineIn,
  output wire doneLineOut,
  output wire doneLineOe,
  // Start-up events
  output wire ioBlockActive,
  output wire globalSetResetHold
);
  // Register state
  reg [1:0] mode_q;
  reg [`TAP_W-1:0] doneTap_q;
  reg [`TAP_W-1:0] ioTap_q;
  reg [`TAP_W-1:0] gsrTap_q;
  reg [`CNT_W-1:0] length_q;
  // Restart is a one-cycle strobe that re-arms counter and stages
  reg restart_q;
  reg ack_q;
  reg [31:0] rdata_q;

  // Sequencer state
  reg [`STAGE_W-1:0] stage_q;
  reg doneOe_q;
  reg ioActive_q;
  reg gsrHold_q;

  wire oscLevel;
  wire oscRise;
  wire userRise;
  wire initHigh;
  wire doneLine;
  wire [`CNT_W-1:0] cfgCount;
  wire countMatch;
  wire startCond;
  wire startEdge;
  wire advance;
  wire waitMode;
  wire doneRelease;
  wire ioRelease;
  wire gsrRelease;
  wire busReq;
  wire busWrite;
  reg [31:0] ctrlWord;
  wire [31:0] ctrlNew;
  wire [31:0] lengthNew;
  reg [31:0] statusWord;

  // Pin synchronisers
  pin_sync_edge uOscSync (
    .clk(clk),
    .srst(srst),
    .pinIn(configOscClock),
    .level(oscLevel),
    .rise(oscRise)
  );

  pin_sync_edge uUserSync (
    .clk(clk),
    .srst(srst),
    .pinIn(userStartupClock),
    .level(),
    .rise(userRise)
  );

  pin_sync_edge uInitSync (
    .clk(clk),
    .srst(srst),
    .pinIn(clearFinished),
    .level(initHigh),
    .rise()
  );

  pin_sync_edge uDoneSync (
    .clk(clk),
    .srst(srst),
    .pinIn(doneLineIn),
    .level(doneLine),
    .rise()
  );

  // Counts oscillator edges only while the clear-finished pin is high
  // It keeps counting after start; only a restart or a low clear-finished pin re-arms the match
  config_length_counter uCounter (
    .clk(clk),
    .srst(srst),
    .clear(~initHigh | restart_q),
    .countEn(oscRise & initHigh),
    .lengthCount(length_q),
    .count(cfgCount),
    .match(countMatch)
  );

  // Byte-lane merge for Wishbone writes
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0] sel;
    integer b;
    begin
      mergeBytes = oldWord;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          mergeBytes[b*8 +: 8] = newWord[b*8 +: 8];
        end
      end
    end
  endfunction

  // Tap select; codes past the last stage pick the last stage
  function tapPick;
    input [`STAGE_W-1:0] stages;
    input [`TAP_W-1:0] tap;
    begin
      if (tap > `STAGE_LAST) begin
        tapPick = stages[`STAGE_LAST];
      end else begin
        tapPick = stages[tap];
      end
    end
  endfunction

  // Wishbone slave: one wait state, ack drops after one cycle
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
  assign busWrite = busReq & wb_we_i;

  // Unused bits read zero; restart is a strobe and reads zero too
  always @* begin
    ctrlWord = 32'h00000000;
    ctrlWord[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_q;
    ctrlWord[`CTRL_DTAP_HI:`CTRL_DTAP_LO] = doneTap_q;
    ctrlWord[`CTRL_ITAP_HI:`CTRL_ITAP_LO] = ioTap_q;
    ctrlWord[`CTRL_GTAP_HI:`CTRL_GTAP_LO] = gsrTap_q;
  end
  assign ctrlNew = mergeBytes(ctrlWord, wb_dat_i, wb_sel_i);
  assign lengthNew = mergeBytes({8'h00, length_q}, wb_dat_i, wb_sel_i);

  always @* begin
    statusWord = 32'h00000000;
    statusWord[`ST_STAGE_HI:`ST_STAGE_LO] = stage_q;
    statusWord[`ST_MATCH] = countMatch;
    statusWord[`ST_MEMFULL] = memFull;
    statusWord[`ST_DONELINE] = doneLine;
    statusWord[`ST_IOACT] = ioActive_q;
    statusWord[`ST_GSRHOLD] = gsrHold_q;
    statusWord[`ST_DONEREL] = ~doneOe_q;
  end

  always @(posedge clk) begin
    if (srst) begin
      mode_q <= `MODE_RST;
      doneTap_q <= `DTAP_RST;
      ioTap_q <= `ITAP_RST;
      gsrTap_q <= `GTAP_RST;
      length_q <= `LENGTH_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      // Status, count and unmapped offsets ignore writes
      if (busWrite) begin
        case (wb_adr_i)
          `OFS_CTRL: begin
            mode_q <= ctrlNew[`CTRL_MODE_HI:`CTRL_MODE_LO];
            doneTap_q <= ctrlNew[`CTRL_DTAP_HI:`CTRL_DTAP_LO];
            ioTap_q <= ctrlNew[`CTRL_ITAP_HI:`CTRL_ITAP_LO];
            gsrTap_q <= ctrlNew[`CTRL_GTAP_HI:`CTRL_GTAP_LO];
            restart_q <= wb_sel_i[3] & wb_dat_i[`CTRL_RESTART];
          end
          `OFS_LENGTH: begin
            length_q <= lengthNew[`CNT_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= busReq;
      // Captured when taken, so the word stands while ack is high
      if (busReq && !wb_we_i) begin
        case (wb_adr_i)
          `OFS_CTRL: rdata_q <= ctrlWord;
          `OFS_LENGTH: rdata_q <= {8'h00, length_q};
          `OFS_STATUS: rdata_q <= statusWord;
          `OFS_COUNT: rdata_q <= {8'h00, cfgCount};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Start condition sampled on an oscillator rising edge
  assign startCond = memFull & countMatch & initHigh;
  // Taken only on an oscillator edge, the edge after the count matched
  assign startEdge = oscRise & startCond;

  // User clock mode bridges the phase at stage one, at no extra cycle over the oscillator modes
  assign advance = mode_q[`CTRL_USER_BIT] ? userRise : oscRise;
  assign waitMode = mode_q[`CTRL_WAIT_BIT];
  // Limitation: in a wait mode the done tap must sit below stage three,
  // or the device holds its own line low and start-up never finishes

  // Stage zero is sticky; a start edge wins over a restart in one cycle
  always @(posedge clk) begin
    if (srst) begin
      stage_q[0] <= 1'b0;
    end else if (startEdge) begin
      stage_q[0] <= 1'b1;
    end else if (restart_q) begin
      stage_q[0] <= 1'b0;
    end
  end

  // Stages beyond zero shift on the selected start-up clock
  genvar i;
  generate
    for (i = 1; i < `STAGE_W; i = i + 1) begin : gStage
      always @(posedge clk) begin
        if (srst || restart_q) begin
          stage_q[i] <= 1'b0;
        end else if (!stage_q[0]) begin
          stage_q[i] <= 1'b0;
        end else if (advance) begin
          if (i == 1) begin
            stage_q[i] <= stage_q[i-1];
          end else if (i == `STAGE_WAIT && waitMode) begin
            // Line held low by any party stalls the shift here
            stage_q[i] <= stage_q[i-1] & doneLine;
          end else begin
            stage_q[i] <= stage_q[i-1];
          end
        end
      end
    end
  endgenerate

  // Taps may share a stage; those events then fall in the same clock
  assign doneRelease = tapPick(stage_q, doneTap_q);
  assign ioRelease = tapPick(stage_q, ioTap_q);
  assign gsrRelease = tapPick(stage_q, gsrTap_q);

  // Event outputs; done is open drain and only ever pulls low
  // Registered, so each event lags its tap stage by one clock
  always @(posedge clk) begin
    if (srst) begin
      doneOe_q <= 1'b1;
      ioActive_q <= 1'b0;
      gsrHold_q <= 1'b1;
    end else begin
      doneOe_q <= ~doneRelease;
      ioActive_q <= ioRelease;
      gsrHold_q <= ~gsrRelease;
    end
  end

  // High level comes from the pull-up, never from this pin
  assign doneLineOut = 1'b0;
  assign doneLineOe = doneOe_q;
  assign ioBlockActive = ioActive_q;
  assign globalSetResetHold = gsrHold_q;
endmodule // config_startup_sequencer

// ---- bench/startup_seq_asserts.sv ----
// Port checker for the start-up sequencer
`timescale 1ns/1ps
module startup_seq_asserts (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Bus handshake
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o,
  // Start-up outputs
  input wire doneLineOut,
  input wire doneLineOe,
  input wire ioBlockActive,
  input wire globalSetResetHold
);
  logic [2:0] wrAge_q;
  wire quiet = wrAge_q == 3'h7;
  // A restart or tap write may move outputs for a few cycles
  always_ff @(posedge clk) begin
    if (srst || (wb_cyc_i && wb_stb_i && wb_we_i)) wrAge_q <= 3'h0;
    else if (!quiet) wrAge_q <= wrAge_q + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o)
    |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_reset_outputs: assert property (disable iff (1'b0) srst |=>
    doneLineOe && !ioBlockActive && globalSetResetHold && !wb_ack_o)
    else $error("outputs wrong after reset");
  a_done_drain_low: assert property (!doneLineOut)
    else $error("done line driven high");
  a_done_sticky: assert property (!doneLineOe && quiet |=> !doneLineOe)
    else $error("done line pulled again");
  a_io_sticky: assert property (ioBlockActive && quiet |=> ioBlockActive)
    else $error("io blocks dropped");
  a_gsr_sticky: assert property (!globalSetResetHold && quiet
    |=> !globalSetResetHold) else $error("set reset reasserted");
  cover property ($fell(doneLineOe));
  cover property ($rose(ioBlockActive));
  cover property ($fell(globalSetResetHold));
endmodule // startup_seq_asserts

bind config_startup_sequencer startup_seq_asserts chk_u (.clk, .srst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .doneLineOut, .doneLineOe,
  .ioBlockActive, .globalSetResetHold);

// ---- bench/done_line_peer.sv ----
// Far-side device sharing the wired-AND done line
`timescale 1ns/1ps
module done_line_peer (
  // Device side
  input wire doneLineOut,
  input wire doneLineOe,
  // Peer hold request
  input wire holdLow,
  // Resolved line, pulled up
  output wire doneLine
);
  // Pull-up wins unless some party sinks the line
  assign doneLine = !(holdLow || (doneLineOe && !doneLineOut));
endmodule // done_line_peer

// ---- bench/tb_config_startup_sequencer.sv ----
// Self-checking bench for the start-up sequencer
`include "startup_seq_regs.vh"
`timescale 1ns/1ps
module tb_config_startup_sequencer;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic configOscClock = 1'b0;
  logic userStartupClock = 1'b0;
  logic clearFinished = 1'b0;
  logic memFull = 1'b0;
  logic holdLow = 1'b0;
  logic [31:0] lfsr = 32'h1855BD0B;
  logic [31:0] rd;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, doneLineIn, doneLineOut, doneLineOe;
  wire ioBlockActive, globalSetResetHold;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int tDone, tIo, tGsr, len, doneTick;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (doneLineOe === 1'b0 && tDone < 0) tDone <= cyc;
    if (ioBlockActive === 1'b1 && tIo < 0) tIo <= cyc;
    if (globalSetResetHold === 1'b0 && tGsr < 0) tGsr <= cyc;
  end
  config_startup_sequencer dut_u (.clk, .srst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .configOscClock, .userStartupClock, .clearFinished, .memFull,
    .doneLineIn, .doneLineOut, .doneLineOe, .ioBlockActive,
    .globalSetResetHold);
  done_line_peer peer_u (.doneLineOut, .doneLineOe, .holdLow,
    .doneLine(doneLineIn));
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Restart with the given taps and clock mode
  function automatic logic [31:0] ctrlWord(input logic [1:0] m,
    input logic [2:0] d, io, g);
    return {1'b1, 16'h0, g, 1'b0, io, 1'b0, d, 2'b00, m};
  endfunction
  // Tap codes past the last stage act as the last stage
  function automatic int stageOf(input logic [2:0] t);
    return (t > 3'h4) ? 4 : int'(t);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'b11, we, a, 4'hF, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t bus ack timeout", $time);
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  // One slow start-up clock period; both clocks idle low between
  task automatic tick(input logic useUser);
    @(posedge clk);
    if (useUser) userStartupClock <= 1'b1;
    else configOscClock <= 1'b1;
    repeat (4) @(posedge clk);
    {configOscClock, userStartupClock} <= 2'b00;
    repeat (3) @(posedge clk);
  endtask
  task automatic runMode(input logic [1:0] m, input logic [2:0] dT, iT, gT);
    wb(1'b1, `OFS_CTRL, ctrlWord(m, dT, iT, gT));
    holdLow <= 1'b1;
    // Outputs fall back two clocks after the restart; skip the old levels
    repeat (3) @(posedge clk);
    tDone = -1;
    tIo = -1;
    tGsr = -1;
    doneTick = 0;
    for (int i = 1; i <= len + 8; i++) begin
      tick(m[1] && i > len + 1);
      if (doneLineOe === 1'b0 && doneTick == 0) doneTick = i;
      if (i == len + 6) begin
        chk(globalSetResetHold, m[0], "stall");
        holdLow <= 1'b0;
      end
    end
    chk(doneTick, len + 1 + stageOf(dT), "start");
    chk(globalSetResetHold, 1'b0, "release");
    if (!m[0]) begin
      chk(tIo - tDone, 8 * (stageOf(iT) - stageOf(dT)), "io delay");
      chk(tGsr - tIo, 8 * (stageOf(gT) - stageOf(iT)), "gsr delay");
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    lfsr = nextRand(lfsr);
    len = 3 + lfsr[2:0];
    wb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_3210, "ctrl reset");
    wb(1'b0, `OFS_LENGTH, 32'h0);
    chk(rd, 32'h00FF_FFFF, "length reset");
    wb(1'b1, `OFS_LENGTH, len);
    wb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
    wb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h0000_2000, "status");
    clearFinished <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (len + 4) tick(1'b0);
    chk(doneLineOe, 1'b1, "no start");
    wb(1'b0, `OFS_COUNT, 32'h0);
    chk(rd, len + 4, "count");
    memFull <= 1'b1;
    for (int m = 0; m < 4; m++) runMode(m[1:0], 3'h1, 3'h2, 3'h3);
    // Corner case: stage zero tap and a code past the last stage
    runMode(2'h0, 3'h0, 3'h2, 3'h7);
    lfsr = nextRand(lfsr);
    runMode(2'h0, lfsr[2:0], lfsr[5:3], lfsr[8:6]);
    print_verdict();
  end
  initial begin
    #50us;
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_config_startup_sequencer
